// >>> jpeg_pkg.sv
package jpeg_pkg;

  // ----------------------------------------------------------------
  // Widths and arithmetic constants
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int COS_FRAC = 11;
  localparam int BUF_W = 40;
  localparam logic signed [8:0] LEVEL_SHIFT = 9'sh080;
  localparam logic signed [31:0] COS_HALF = 32'sh00000400;
  localparam logic signed [11:0] COS_DC = 12'sh2d4;
  localparam logic signed [11:0] COS_K [9] = '{12'sh400, 12'sh3ec,
    12'sh3b2, 12'sh353, 12'sh2d4, 12'sh239, 12'sh188, 12'sh0c8, 12'sh000};
  localparam logic signed [10:0] COEF_MAX = 11'sh3ff;
  localparam logic signed [10:0] COEF_MIN = 11'sh400;
  localparam logic signed [11:0] PRED_RESET = 12'sh000;

  // ----------------------------------------------------------------
  // Formats, vertical up-scale ratio, symbols and markers
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_422_PLANAR = 2'h2;
  localparam logic [1:0] FMT_420_PLANAR = 2'h3;
  localparam logic [13:0] UP_NUM = 14'h0005;
  localparam logic [13:0] UP_DEN = 14'h0006;
  localparam logic [7:0] AC_ZRL = 8'hf0;
  localparam logic [7:0] AC_EOB = 8'h00;
  localparam logic [7:0] MARK_ESC = 8'hff;
  localparam logic [7:0] STUFF_BYTE = 8'h00;
  localparam logic [7:0] RST_BASE = 8'hd0;

  // Natural coefficient index at each zig-zag position
  localparam logic [5:0] ZIGZAG [64] = '{
    6'h00, 6'h01, 6'h08, 6'h10, 6'h09, 6'h02, 6'h03, 6'h0a,
    6'h11, 6'h18, 6'h20, 6'h19, 6'h12, 6'h0b, 6'h04, 6'h05,
    6'h0c, 6'h13, 6'h1a, 6'h21, 6'h28, 6'h30, 6'h29, 6'h22,
    6'h1b, 6'h14, 6'h0d, 6'h06, 6'h07, 6'h0e, 6'h15, 6'h1c,
    6'h23, 6'h2a, 6'h31, 6'h38, 6'h39, 6'h32, 6'h2b, 6'h24,
    6'h1d, 6'h16, 6'h0f, 6'h17, 6'h1e, 6'h25, 6'h2c, 6'h33,
    6'h3a, 6'h3b, 6'h34, 6'h2d, 6'h26, 6'h1f, 6'h27, 6'h2e,
    6'h35, 6'h3c, 6'h3d, 6'h36, 6'h2f, 6'h37, 6'h3e, 6'h3f};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic we;
    logic chroma;
    logic [5:0] addr;
    logic [7:0] step;
  } qt_load_type;

  typedef struct packed {
    logic we;
    logic ac;
    logic chroma;
    logic [7:0] addr;
    logic [15:0] code;
    logic [4:0] len;
  } ht_load_type;

  typedef struct packed {
    logic [1:0] format;
    logic upscale;
    logic [7:0] width_blocks;
    logic [7:0] height_blocks;
    logic [15:0] restart_blocks;
    logic [ADDR_W-1:0] y_base;
    logic [ADDR_W-1:0] u_base;
    logic [ADDR_W-1:0] v_base;
  } scan_cfg_type;

  typedef enum logic [3:0] {ST_IDLE, ST_FETCH, ST_ROW, ST_COL, ST_DC,
    ST_AC, ST_EOB, ST_NEXT, ST_FLUSH, ST_MARK0, ST_MARK1} state_type;

endpackage : jpeg_pkg

// >>> jpeg_baseline_encoder.sv
`timescale 1ns/1ps
// Summary of operation
// - Baseline sequential DCT process only
// - Blocks fetched left-right, rows top-bottom
// - Subtract 128 from each sample
// - Forward DCT gives 64 coefficients
// - Divide by matching quantization table step
// - Quantized result rounds to nearest integer
// - Two host-loaded 64x8 quantization tables
// - Quantized coefficients are 11-bit signed
// - Coefficients reordered in zig-zag sequence
// - DC coded as difference per component
// - Predictors cleared at scan and restart
// - AC zero runs coded with next nonzero
// - Trailing zeros become one end-of-block
// - Four Huffman tables, DC/AC by luma/chroma
// - Non-interleaved 4:2:2 and 4:2:0 orders
// - Only planar capture formats are compressed
// - Optional vertical up-scale from 240 lines
module jpeg_baseline_encoder import jpeg_pkg::*; (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic START_I,
  input wire scan_cfg_type CFG_I,
  input wire qt_load_type QT_LOAD_I,
  input wire ht_load_type HT_LOAD_I,
  output logic MEM_REQ_O,
  output logic [ADDR_W-1:0] MEM_ADDR_O,
  input wire logic MEM_ACK_I,
  input wire logic [7:0] MEM_DATA_I,
  output logic OUT_VALID_O,
  output logic [7:0] OUT_DATA_O,
  input wire logic OUT_READY_I,
  output logic BUSY_O,
  output logic DONE_O
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [11:0] cosv(input logic [2:0] u,
                                              input logic [2:0] x);
    logic [4:0] k;
    logic neg;
    k = 5'(({2'h0, x, 1'b1} * {2'h0, u}));
    if (k > 5'h10) k = 5'h00 - k;
    neg = k > 5'h08;
    if (neg) k = 5'h10 - k;
    cosv = (u == 3'h0) ? COS_DC : COS_K[k[3:0]];
    if (neg) cosv = -cosv;
  endfunction : cosv

  function automatic logic [ADDR_W-1:0] fetch_addr(input scan_cfg_type c,
    input logic [1:0] cp, input logic [7:0] bxx, input logic [7:0] byy,
    input logic [5:0] i);
    logic [13:0] dst;
    logic [13:0] src;
    logic [10:0] pitch;
    logic [ADDR_W-1:0] base;
    dst = {3'h0, byy, i[5:3]};
    src = c.upscale ? 14'((dst * UP_NUM) / UP_DEN) : dst;
    pitch = (cp == 2'h0) ? {c.width_blocks, 3'h0}
      : {1'b0, c.width_blocks, 2'h0};
    base = (cp == 2'h0) ? c.y_base : ((cp == 2'h1) ? c.u_base : c.v_base);
    fetch_addr = base + ADDR_W'(src * pitch) + ADDR_W'({bxx, i[2:0]});
  endfunction : fetch_addr

  function automatic logic [3:0] size_of(input logic [11:0] mag);
    size_of = 4'h0;
    for (int b = 0; b < 11; b++) begin
      if (mag[b]) size_of = 4'(b + 1);
    end
  endfunction : size_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_type state, next_state;
  scan_cfg_type cfg, next_cfg;
  logic [1:0] comp, next_comp;
  logic [7:0] bx, next_bx, by, next_by;
  logic [5:0] idx, next_idx, run, next_run;
  logic [2:0] tap, next_tap, rst_num, next_rst_num;
  logic [15:0] rcount, next_rcount;
  logic mark_after, next_mark_after, done, next_done;
  logic mem_req, next_mem_req;
  logic [ADDR_W-1:0] mem_addr, next_mem_addr;
  logic signed [31:0] acc, next_acc, acc_sum, rnd;
  logic signed [11:0] pred [3];
  logic signed [11:0] next_pred [3];
  logic signed [8:0] smp [64];
  logic signed [15:0] tmp [64];
  logic signed [10:0] qz [64];
  logic [7:0] qtab [128];
  logic [15:0] hcode [1024];
  logic [4:0] hlen [1024];
  logic smp_we, tmp_we, qz_we;
  logic signed [10:0] qv;
  logic [BUF_W-1:0] bitbuf, next_bitbuf;
  logic [5:0] bitcnt, next_bitcnt;
  logic out_valid, next_out_valid, stuff, next_stuff;
  logic [7:0] out_data, next_out_data, mark_byte;
  logic put_valid, put_ready, mark_req, mark_take, pad;
  logic [26:0] put_bits;
  logic [4:0] put_len;
  logic [7:0] blk_w, blk_h, sym;
  logic signed [11:0] ev;
  logic [11:0] ev_mag;
  logic [3:0] sz, sym_sz;
  logic sym_ac;

  // ----------------------------------------------------------------
  // Transform and quantizer datapath
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [31:0] prod;
    logic signed [15:0] coef;
    logic [15:0] mag, qmag;
    logic [7:0] step;
    prod = '0;
    if (state == ST_ROW) begin
      prod = 32'(smp[{idx[5:3], tap}] * cosv(idx[2:0], tap));
    end else begin
      prod = 32'(tmp[{tap, idx[2:0]}] * cosv(idx[5:3], tap));
    end
    acc_sum = acc + prod;
    rnd = (acc_sum + COS_HALF) >>> COS_FRAC;
    coef = rnd[15:0];
    step = qtab[{comp != 2'h0, idx}];
    if (step == 8'h00) step = 8'h01;
    mag = coef[15] ? 16'(-coef) : 16'(coef);
    qmag = (mag + {9'h0, step[7:1]}) / {8'h0, step};
    if (!coef[15] && qmag > 16'h03ff) begin
      qv = COEF_MAX;
    end else if (coef[15] && qmag > 16'h0400) begin
      qv = COEF_MIN;
    end else begin
      qv = coef[15] ? -11'(qmag) : 11'(qmag);
    end
  end

  // ----------------------------------------------------------------
  // Symbol and Huffman lookup
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [11:0] am;
    logic [26:0] mask;
    logic [9:0] hi;
    blk_w = (comp == 2'h0) ? cfg.width_blocks : cfg.width_blocks >> 1;
    blk_h = cfg.height_blocks;
    if (comp != 2'h0 && cfg.format == FMT_420_PLANAR) begin
      blk_h = cfg.height_blocks >> 1;
    end
    if (state == ST_DC) begin
      ev = 12'(qz[0]) - pred[comp];
    end else begin
      ev = 12'(qz[ZIGZAG[idx]]);
    end
    ev_mag = ev[11] ? 12'(-ev) : 12'(ev);
    sz = size_of(ev_mag);
    am = ev[11] ? ev - 12'sh001 : ev;
    sym_ac = state != ST_DC;
    sym_sz = sz;
    sym = {4'h0, sz};
    if (state == ST_EOB) begin
      sym = AC_EOB;
      sym_sz = 4'h0;
    end else if (state == ST_AC && run > 6'h0f) begin
      sym = AC_ZRL;
      sym_sz = 4'h0;
    end else if (state == ST_AC) begin
      sym = {run[3:0], sz};
    end
    hi = {sym_ac, comp != 2'h0, sym};
    mask = (27'h1 << sym_sz) - 27'h1;
    pad = state == ST_FLUSH;
    if (pad) begin
      put_bits = {19'h0, 8'hff >> bitcnt[2:0]};
      put_len = 5'h08 - {2'h0, bitcnt[2:0]};
    end else begin
      put_bits = (27'(hcode[hi]) << sym_sz) | (27'(am[10:0]) & mask);
      put_len = hlen[hi] + {1'b0, sym_sz};
    end
  end

  // ----------------------------------------------------------------
  // Control sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic last_blk;
    next_state = state;
    next_cfg = cfg;
    next_comp = comp;
    next_bx = bx;
    next_by = by;
    next_idx = idx;
    next_run = run;
    next_tap = tap;
    next_rst_num = rst_num;
    next_rcount = rcount;
    next_mark_after = mark_after;
    next_done = 1'b0;
    next_mem_req = mem_req;
    next_mem_addr = mem_addr;
    next_acc = acc;
    next_pred = pred;
    smp_we = 1'b0;
    tmp_we = 1'b0;
    qz_we = 1'b0;
    put_valid = 1'b0;
    mark_req = 1'b0;
    mark_byte = MARK_ESC;
    last_blk = (bx == blk_w - 8'h01) && (by == blk_h - 8'h01);
    case (state)
      ST_IDLE: begin
        if (START_I && CFG_I.format[1]) begin
          next_cfg = CFG_I;
          next_comp = 2'h0;
          next_bx = 8'h00;
          next_by = 8'h00;
          next_idx = 6'h00;
          next_rcount = 16'h0000;
          next_rst_num = 3'h0;
          for (int c = 0; c < 3; c++) next_pred[c] = PRED_RESET;
          next_mem_req = 1'b1;
          next_mem_addr = fetch_addr(CFG_I, 2'h0, 8'h00, 8'h00, 6'h00);
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (MEM_ACK_I) begin
          smp_we = 1'b1;
          next_idx = idx + 6'h01;
          next_mem_addr = fetch_addr(cfg, comp, bx, by, next_idx);
          if (idx == 6'h3f) begin
            next_mem_req = 1'b0;
            next_tap = 3'h0;
            next_acc = '0;
            next_state = ST_ROW;
          end
        end
      end
      ST_ROW, ST_COL: begin
        next_tap = tap + 3'h1;
        next_acc = acc_sum;
        if (tap == 3'h7) begin
          tmp_we = state == ST_ROW;
          qz_we = state == ST_COL;
          next_acc = '0;
          next_idx = idx + 6'h01;
          if (idx == 6'h3f) begin
            next_state = (state == ST_ROW) ? ST_COL : ST_DC;
          end
        end
      end
      ST_DC: begin
        put_valid = 1'b1;
        if (put_ready) begin
          next_pred[comp] = 12'(qz[0]);
          next_idx = 6'h01;
          next_run = 6'h00;
          next_state = ST_AC;
        end
      end
      ST_AC: begin
        if (ev == 12'sh000) begin
          next_run = run + 6'h01;
          next_idx = idx + 6'h01;
          if (idx == 6'h3f) next_state = ST_EOB;
        end else begin
          put_valid = 1'b1;
          if (put_ready && run > 6'h0f) begin
            next_run = run - 6'h10;
          end else if (put_ready) begin
            next_run = 6'h00;
            next_idx = idx + 6'h01;
            if (idx == 6'h3f) next_state = ST_NEXT;
          end
        end
      end
      ST_EOB: begin
        put_valid = 1'b1;
        if (put_ready) next_state = ST_NEXT;
      end
      ST_NEXT: begin
        next_mark_after = 1'b0;
        next_state = ST_FLUSH;
        if (!last_blk) begin
          next_bx = bx + 8'h01;
          if (bx == blk_w - 8'h01) begin
            next_bx = 8'h00;
            next_by = by + 8'h01;
          end
          next_idx = 6'h00;
          next_rcount = rcount + 16'h0001;
          if (cfg.restart_blocks != 16'h0000 &&
              rcount == cfg.restart_blocks - 16'h0001) begin
            next_rcount = 16'h0000;
            next_mark_after = 1'b1;
          end else begin
            next_mem_req = 1'b1;
            next_mem_addr = fetch_addr(cfg, comp, next_bx, next_by, 6'h00);
            next_state = ST_FETCH;
          end
        end
      end
      ST_FLUSH: begin
        // Pad with ones to the byte edge, then wait for a fully drained packer
        put_valid = bitcnt[2:0] != 3'h0 && bitcnt < 6'h08;
        if (bitcnt == 6'h00 && !stuff) begin
          if (mark_after) begin
            next_state = ST_MARK0;
          end else if (comp == 2'h2) begin
            next_done = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_comp = comp + 2'h1;
            next_bx = 8'h00;
            next_by = 8'h00;
            next_idx = 6'h00;
            next_rcount = 16'h0000;
            for (int c = 0; c < 3; c++) next_pred[c] = PRED_RESET;
            next_mem_req = 1'b1;
            next_mem_addr = fetch_addr(cfg, next_comp, 8'h00, 8'h00, 6'h00);
            next_state = ST_FETCH;
          end
        end
      end
      ST_MARK0: begin
        mark_req = 1'b1;
        if (mark_take) next_state = ST_MARK1;
      end
      ST_MARK1: begin
        mark_req = 1'b1;
        mark_byte = RST_BASE | {5'h00, rst_num};
        if (mark_take) begin
          next_rst_num = rst_num + 3'h1;
          for (int c = 0; c < 3; c++) next_pred[c] = PRED_RESET;
          next_mem_req = 1'b1;
          next_mem_addr = fetch_addr(cfg, comp, bx, by, 6'h00);
          next_state = ST_FETCH;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Bit packer and byte output
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] shamt;
    shamt = 6'h00;
    put_ready = bitcnt < 6'h08;
    mark_take = (!out_valid || OUT_READY_I) && !stuff;
    next_bitbuf = bitbuf;
    next_bitcnt = bitcnt;
    next_stuff = stuff;
    next_out_valid = out_valid;
    next_out_data = out_data;
    if (!out_valid || OUT_READY_I) begin
      next_out_valid = 1'b0;
      if (stuff) begin
        // A coded 0xff is followed by a zero so it never reads as a marker
        next_out_data = STUFF_BYTE;
        next_out_valid = 1'b1;
        next_stuff = 1'b0;
      end else if (mark_req) begin
        next_out_data = mark_byte;
        next_out_valid = 1'b1;
      end else if (bitcnt >= 6'h08) begin
        next_out_data = bitbuf[BUF_W-1 -: 8];
        next_out_valid = 1'b1;
        next_stuff = bitbuf[BUF_W-1 -: 8] == MARK_ESC;
        next_bitbuf = bitbuf << 8;
        next_bitcnt = bitcnt - 6'h08;
      end
    end
    if (put_valid && put_ready) begin
      shamt = 6'(BUF_W) - bitcnt - {1'b0, put_len};
      next_bitbuf = bitbuf | (BUF_W'(put_bits) << shamt);
      next_bitcnt = bitcnt + {1'b0, put_len};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= ST_IDLE;
      cfg <= '0;
      comp <= 2'h0;
      bx <= 8'h00;
      by <= 8'h00;
      idx <= 6'h00;
      run <= 6'h00;
      tap <= 3'h0;
      rst_num <= 3'h0;
      rcount <= 16'h0000;
      mark_after <= 1'b0;
      done <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= '0;
      acc <= '0;
      for (int c = 0; c < 3; c++) pred[c] <= PRED_RESET;
      bitbuf <= '0;
      bitcnt <= 6'h00;
      stuff <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      comp <= next_comp;
      bx <= next_bx;
      by <= next_by;
      idx <= next_idx;
      run <= next_run;
      tap <= next_tap;
      rst_num <= next_rst_num;
      rcount <= next_rcount;
      mark_after <= next_mark_after;
      done <= next_done;
      mem_req <= next_mem_req;
      mem_addr <= next_mem_addr;
      acc <= next_acc;
      pred <= next_pred;
      bitbuf <= next_bitbuf;
      bitcnt <= next_bitcnt;
      stuff <= next_stuff;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  // Tables are not guarded against loads during a scan; load while idle
  always_ff @(posedge REF_CLK_I) begin
    if (smp_we) smp[idx] <= $signed({1'b0, MEM_DATA_I}) - LEVEL_SHIFT;
    if (tmp_we) tmp[idx] <= rnd[15:0];
    if (qz_we) qz[idx] <= qv;
    if (QT_LOAD_I.we) begin
      qtab[{QT_LOAD_I.chroma, QT_LOAD_I.addr}] <= QT_LOAD_I.step;
    end
    if (HT_LOAD_I.we) begin
      hcode[{HT_LOAD_I.ac, HT_LOAD_I.chroma, HT_LOAD_I.addr}] <=
        HT_LOAD_I.code;
      hlen[{HT_LOAD_I.ac, HT_LOAD_I.chroma, HT_LOAD_I.addr}] <= HT_LOAD_I.len;
    end
  end

  assign MEM_REQ_O = mem_req;
  assign MEM_ADDR_O = mem_addr;
  assign OUT_VALID_O = out_valid;
  assign OUT_DATA_O = out_data;
  assign BUSY_O = state != ST_IDLE;
  assign DONE_O = done;

endmodule : jpeg_baseline_encoder

// >>> jpeg_encoder_props.sv
`timescale 1ns/1ps
module jpeg_encoder_props import jpeg_pkg::*; (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic START_I,
  input wire scan_cfg_type CFG_I,
  input wire logic MEM_REQ_O,
  input wire logic [ADDR_W-1:0] MEM_ADDR_O,
  input wire logic MEM_ACK_I,
  input wire logic OUT_VALID_O,
  input wire logic [7:0] OUT_DATA_O,
  input wire logic OUT_READY_I,
  input wire logic BUSY_O,
  input wire logic DONE_O
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [6:0] acks;
  logic after_esc;
  logic [6:0] next_acks;
  logic next_after_esc;

  always_comb begin
    next_acks = MEM_REQ_O ? acks + {6'h00, MEM_ACK_I} : 7'h00;
    next_after_esc = after_esc;
    if (OUT_VALID_O && OUT_READY_I) begin
      next_after_esc = OUT_DATA_O == MARK_ESC;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      acks <= 7'h00;
      after_esc <= 1'b0;
    end else begin
      acks <= next_acks;
      after_esc <= next_after_esc;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_reset_quiet: assert property (
    $rose(RESET_N_I) |-> !MEM_REQ_O && !OUT_VALID_O && !BUSY_O && !DONE_O)
    else $error("outputs active after reset");
  a_start_fetch: assert property (
    START_I && !BUSY_O && CFG_I.format[1] |=> BUSY_O && MEM_REQ_O
    && MEM_ADDR_O == $past(CFG_I.y_base))
    else $error("start did not fetch first luma sample");
  a_bad_format: assert property (
    START_I && !BUSY_O && !CFG_I.format[1] |=> !BUSY_O && !MEM_REQ_O)
    else $error("packed format started a frame");
  a_addr_hold: assert property (
    MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O))
    else $error("sample request dropped or moved");
  a_addr_step: assert property (
    MEM_REQ_O && MEM_ACK_I && MEM_ADDR_O[2:0] != 3'h7
    |=> MEM_ADDR_O == $past(MEM_ADDR_O) + 22'h000001)
    else $error("sample address not sequential in row");
  a_block_len: assert property (
    $fell(MEM_REQ_O) |-> acks == 7'h40)
    else $error("block fetch not 64 samples");
  a_idle_silent: assert property (
    !BUSY_O |-> !MEM_REQ_O)
    else $error("fetch while idle");
  a_out_hold: assert property (
    OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_DATA_O))
    else $error("output byte not held");
  a_stuff_zero: assert property (
    OUT_VALID_O && after_esc |-> OUT_DATA_O == STUFF_BYTE
    || OUT_DATA_O[7:3] == RST_BASE[7:3])
    else $error("escape byte not followed by stuffing");
  a_done_pulse: assert property (
    DONE_O |-> $past(BUSY_O) ##1 !DONE_O)
    else $error("done not a single pulse after busy");
endmodule : jpeg_encoder_props

bind jpeg_baseline_encoder jpeg_encoder_props i_props (
  .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .START_I(START_I),
  .CFG_I(CFG_I), .MEM_REQ_O(MEM_REQ_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_ACK_I(MEM_ACK_I), .OUT_VALID_O(OUT_VALID_O),
  .OUT_DATA_O(OUT_DATA_O), .OUT_READY_I(OUT_READY_I), .BUSY_O(BUSY_O),
  .DONE_O(DONE_O));

// >>> jpeg_partner_model.sv
`timescale 1ns/1ps
module jpeg_partner_model import jpeg_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic [7:0] fill_i,
  input wire logic mem_req_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [7:0] mem_data_o,
  input wire logic out_valid_i,
  input wire logic [7:0] out_data_i,
  output logic out_ready_o
);
  logic [3:0] tick;
  logic [ADDR_W-1:0] addr_log [$];
  logic [7:0] byte_log [$];

  initial begin
    tick = 4'h0;
    mem_ack_o = 1'b0;
    out_ready_o = 1'b0;
  end

  // Off-ack data is inverted so a stale sample never looks valid
  assign mem_data_o = mem_ack_o ? fill_i : ~fill_i;

  always @(posedge clk_i) begin
    if (rst_n_i && mem_req_i && mem_ack_o) begin
      addr_log.push_back(mem_addr_i);
    end
    if (rst_n_i && out_valid_i && out_ready_o) begin
      byte_log.push_back(out_data_i);
    end
  end

  // Slow mode stalls both sides to exercise back-pressure
  always @(negedge clk_i) begin
    tick <= tick + 4'h1;
    mem_ack_o <= rst_n_i && mem_req_i && (!slow_i || tick[1:0] == 2'h0);
    out_ready_o <= rst_n_i && (!slow_i || tick[0]);
  end
endmodule : jpeg_partner_model

// >>> jpeg_baseline_encoder_tb.sv
`timescale 1ns/1ps
module jpeg_baseline_encoder_tb import jpeg_pkg::*;;
  localparam logic [ADDR_W-1:0] YB = 22'h000100;
  localparam logic [ADDR_W-1:0] UB = 22'h001000;
  localparam logic [ADDR_W-1:0] VB = 22'h002000;
  logic clk, reset_n, start, mem_req, mem_ack, out_valid, out_ready;
  logic busy, done, slow;
  logic [7:0] mem_data, out_data, fill;
  logic [ADDR_W-1:0] mem_addr;
  scan_cfg_type cfg;
  qt_load_type qt_load;
  ht_load_type ht_load;
  int fail_count, total_checks;

  jpeg_baseline_encoder i_dut (.REF_CLK_I(clk), .RESET_N_I(reset_n),
    .START_I(start), .CFG_I(cfg), .QT_LOAD_I(qt_load),
    .HT_LOAD_I(ht_load), .MEM_REQ_O(mem_req), .MEM_ADDR_O(mem_addr),
    .MEM_ACK_I(mem_ack), .MEM_DATA_I(mem_data), .OUT_VALID_O(out_valid),
    .OUT_DATA_O(out_data), .OUT_READY_I(out_ready), .BUSY_O(busy),
    .DONE_O(done));
  jpeg_partner_model i_part (.clk_i(clk), .rst_n_i(reset_n),
    .slow_i(slow), .fill_i(fill), .mem_req_i(mem_req),
    .mem_addr_i(mem_addr), .mem_ack_o(mem_ack), .mem_data_o(mem_data),
    .out_valid_i(out_valid), .out_data_i(out_data),
    .out_ready_o(out_ready));

  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic check8(input string what, input logic [7:0] e,
    input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check8

  task automatic check_addr(input string what, input logic [21:0] e,
    input logic [21:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check_addr

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic load_ht(input logic ac, input logic ch,
    input logic [7:0] sym, input logic [15:0] code, input logic [4:0] n);
    ht_load = '{1'b1, ac, ch, sym, code, n};
    @(negedge clk);
  endtask : load_ht

  task automatic run_frame(input logic [1:0] fmt, input logic [7:0] hb,
    input logic [7:0] smp, input logic slw);
    int n;
    i_part.addr_log.delete();
    i_part.byte_log.delete();
    fill = smp;
    slow = slw;
    // Slow runs also up-scale and restart every two blocks
    cfg = '{fmt, slw, 8'h02, hb, {14'h0, slw, 1'b0}, YB, UB, VB};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    // Last byte may still sit in the output register after done
    while (out_valid !== 1'b0 && n < 40100) begin
      @(negedge clk);
      n++;
    end
    check8("frame finished", 8'h01, {7'h00, n < 40000});
  endtask : run_frame

  task automatic check_stream(input logic [7:0] e[$]);
    check8("byte count", 8'(e.size()), 8'(i_part.byte_log.size()));
    foreach (e[i]) begin
      if (i < i_part.byte_log.size()) begin
        check8("coded byte", e[i], i_part.byte_log[i]);
      end
    end
  endtask : check_stream

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bad_format;
    for (int f = 0; f < 2; f++) begin
      cfg.format = 2'(f);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (3) @(negedge clk);
      check8("packed start ignored", 8'h00, {6'h00, busy, mem_req});
    end
  endtask : t_bad_format

  task automatic t_flat_422;
    run_frame(FMT_422_PLANAR, 8'h01, 8'h80, 1'b0);
    check_stream('{8'h28, 8'haf, 8'h4f, 8'h4f});
    check_addr("samples", 22'd256, 22'(i_part.addr_log.size()));
    check_addr("row 1", YB + 22'h10, i_part.addr_log[8]);
    check_addr("block 1", YB + 22'h08, i_part.addr_log[64]);
    check_addr("u start", UB, i_part.addr_log[128]);
    check_addr("u row 1", UB + 22'h08, i_part.addr_log[136]);
    check_addr("v start", VB, i_part.addr_log[192]);
  endtask : t_flat_422

  task automatic t_dc_slow;
    run_frame(FMT_422_PLANAR, 8'h02, 8'h88, 1'b1);
    check_stream('{8'h5a, 8'h2b, 8'hff, 8'hd0, 8'h5a, 8'h2b,
      8'h91, 8'h3f, 8'h91, 8'h3f});
    check_addr("up-scaled row", YB + 22'h60, i_part.addr_log[128]);
  endtask : t_dc_slow

  task automatic t_order_420;
    run_frame(FMT_420_PLANAR, 8'h02, 8'h80, 1'b0);
    check_stream('{8'h28, 8'ha2, 8'h8a, 8'h4f, 8'h4f});
    check_addr("samples", 22'd384, 22'(i_part.addr_log.size()));
    check_addr("block row 1", YB + 22'h80, i_part.addr_log[128]);
    check_addr("u start", UB, i_part.addr_log[256]);
    check_addr("v start", VB, i_part.addr_log[320]);
  endtask : t_order_420

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #400000;
    fail_count++;
    finish_test();
  end

  initial begin
    reset_n = 1'b0;
    start = 1'b0;
    slow = 1'b0;
    fill = 8'h80;
    cfg = '0;
    qt_load = '0;
    ht_load = '0;
    fail_count = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check8("reset", 8'h00, {4'h0, busy, done, mem_req, out_valid});
    // DC step 80 makes 65/80 round up to 1, truncation would give 0
    for (int i = 0; i < 128; i++) begin
      qt_load = '{1'b1, i[6], i[5:0], (i[5:0] == 6'h00) ? 8'h50 : 8'hff};
      @(negedge clk);
    end
    qt_load.we = 1'b0;
    load_ht(1'b0, 1'b0, 8'h00, 16'h0000, 5'h02);
    load_ht(1'b0, 1'b0, 8'h01, 16'h0002, 5'h03);
    load_ht(1'b1, 1'b0, AC_EOB, 16'h000a, 5'h04);
    load_ht(1'b0, 1'b1, 8'h00, 16'h0001, 5'h02);
    load_ht(1'b0, 1'b1, 8'h01, 16'h0004, 5'h03);
    load_ht(1'b1, 1'b1, AC_EOB, 16'h0000, 5'h02);
    ht_load.we = 1'b0;
    t_bad_format();
    t_flat_422();
    t_dc_slow();
    t_order_420();
    finish_test();
  end
endmodule : jpeg_baseline_encoder_tb
